/* File: dbuf_defines.svh */
/*
  Constants of the three-bus data buffer: queue sizes, reset values and
  bus fill values. Assumes it is included by its bare name.
*/
`ifndef DBUF_DEFINES_SVH
`define DBUF_DEFINES_SVH

// ----------------------------------------------------------------------
// Queue geometry
// ----------------------------------------------------------------------
`define DBUF_CP_ENTRIES 4
`define DBUF_CP_DW_PER_ENTRY 4
`define DBUF_CP_DEPTH 16
`define DBUF_CM_DEPTH 4

// ----------------------------------------------------------------------
// Reset and fill values
// ----------------------------------------------------------------------
`define DBUF_RST_QW 64'h0000_0000_0000_0000
`define DBUF_RST_DW 32'h0000_0000
`define DBUF_RST_PAR 8'h00
`define DBUF_ABORT_QW 64'hFFFF_FFFF_FFFF_FFFF
`define DBUF_PAR_ODD 1'b0

`endif

/* File: dbuf_pkg.sv */
/*
  Types of the three-bus data buffer: controller strobes, status and the
  state of the datapath. Assumes dbuf_defines.svh sits beside it.
*/
package dbuf_pkg;

  // Strobes from the system controller, one clock, all active high
  typedef struct packed {
    logic cm_push;      // host word into cpu_to_memory_write_queue
    logic cm_pop;       // queue head onto memory_data_bus
    logic cp_push;      // host dword into cpu_to_pci_write_queue
    logic cp_io;        // the pushed dword is an I/O write
    logic cp_pop;       // queue head onto the AD bus
    logic crm_le;       // capture memory data for the CPU
    logic crm_oe;       // drive memory_to_cpu_read_latch to host
    logic prm_le_mem;   // capture memory data for a PCI read
    logic prm_le_host;  // capture host data (modified line) for PCI
    logic prm_sel;      // dword of memory_to_pci_read_latch to drive
    logic prm_oe;       // drive selected dword onto the AD bus
    logic ptm_le;       // latch AD into pci_to_memory_write_latch
    logic ptm_sel;      // dword slot of that latch
    logic ptm_mem_oe;   // write the latch to memory
    logic ptm_host_oe;  // drive the latch onto the host bus
    logic abort_oe;     // master abort: supply host data ourselves
  } dbuf_ctrl_s;

  typedef struct packed {
    logic cp_full;
    logic cp_empty;
    logic cm_full;
    logic cm_empty;
    logic io_wait;
    logic par_err;
  } dbuf_stat_s;

  typedef struct packed {
    logic [63:0] crm;
    logic [63:0] prm;
    logic [63:0] ptm;
    logic [63:0] host_out;
    logic host_oe;
    logic [63:0] mem_out;
    logic [7:0] mem_par;
    logic mem_oe;
    logic [31:0] ad_out;
    logic ad_oe;
    logic par_err;
    logic io_wait;
  } dbuf_state_s;

endpackage

/* File: dbuf_par.sv */
/*
  Byte-lane parity for a 64-bit quadword, one bit per byte.
  Assumes nothing of its surroundings; purely combinational.
*/
`timescale 1ns/1ns
module dbuf_par #(
  parameter bit ODD = 1'b0
) (
  input wire logic [63:0] data, // quadword
  output logic [7:0] par        // one parity bit per byte
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      par[i] = (^data[i*8 +: 8]) ^ ODD;
    end
  end
endmodule

/* File: dbuf_fifo.sv */
/*
  Synchronous FIFO with registered outputs, used as a posted write queue.
  Assumes writer and reader share one clock; data push only when in_ready.
*/
`timescale 1ns/1ns
module dbuf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,                // clock
  input wire logic rst,                // async reset, high
  input wire logic in_valid,           // push request
  input wire logic [WIDTH-1:0] in_data, // push data
  output logic in_ready,               // room for a push
  output logic out_valid,              // head word present
  output logic [WIDTH-1:0] out_data,   // head word
  input wire logic out_ready,          // pop request
  output logic full,                   // no free entry
  output logic empty                   // nothing queued
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] head;
    logic vld;
    logic rdy;
  } dbuf_fifo_s;

  dbuf_fifo_s st_r;
  dbuf_fifo_s st_nxt;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    logic do_push;
    logic do_pop;
    do_push = in_valid && st_r.rdy;
    do_pop = out_ready && st_r.vld;
    st_nxt = st_r;
    if (do_push) begin
      st_nxt.mem[st_r.wr] = in_data;
      st_nxt.wr = bump(st_r.wr);
    end
    if (do_pop) begin
      st_nxt.rd = bump(st_r.rd);
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    // Head is read from the next image so a push into empty shows at once
    st_nxt.head = st_nxt.mem[st_nxt.rd];
    st_nxt.vld = (st_nxt.cnt != '0);
    st_nxt.rdy = (st_nxt.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.rdy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready = st_r.rdy;
  assign out_valid = st_r.vld;
  assign out_data = st_r.head;
  assign full = !st_r.rdy;
  assign empty = !st_r.vld;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  no_overflow_a: assert property (
    st_r.cnt <= (AW+1)'(DEPTH)) else $error("fifo count past depth");
  full_holds_a: assert property (
    (full && !out_ready) |=> full) else $error("full dropped without pop");
endmodule

/* File: dbuf_top.sv */
/*
  Data buffer between a 64-bit host data bus, a 64-bit memory data bus
  and the 32-bit PCI AD bus: two posted write queues, three latches,
  parity generation and checking. Assumes the system controller drives
  every strobe synchronously to clk and resolves bus turnarounds.
*/
`timescale 1ns/1ns
`include "dbuf_defines.svh"

// How it works
// - host writes and write-backs go to memory
// - CPU memory writes pass through the write queue
// - memory read captured for CPU hold time
// - check parity on CPU memory reads
// - host data routed to PCI bus
// - PCI writes queued, drained when bus free
// - full PCI queue holds off further writes
// - I/O writes queued but not posted
// - L2 data to PCI via read latch
// - CPU PCI read waits for empty queue
// - PCI read dwords assembled before host
// - parity generated on PCI memory writes
// - PCI memory reads via read latch
// - no parity check toward PCI
// - controller strobes command every transfer
// - PCI queue holds four entries
// - memory queue holds one burst line
// - synchronous to the one clock
module dbuf_top
  import dbuf_pkg::*;
#(
  parameter int CP_DEPTH = `DBUF_CP_DEPTH,
  parameter int CM_DEPTH = `DBUF_CM_DEPTH
) (
  input wire logic clk,                // 100 MHz clock
  input wire logic rst,                // async reset, high
  input wire dbuf_ctrl_s ctrl,         // controller strobes
  output dbuf_stat_s stat,             // queue and check status
  input wire logic [63:0] host_data_in, // host_data_bus sampled
  output logic [63:0] host_data_out,   // host_data_bus driven
  output logic host_data_oe,           // host_data_bus enable
  input wire logic [63:0] mem_data_in, // memory_data_bus sampled
  input wire logic [7:0] mem_par_in,   // memory parity sampled
  output logic [63:0] mem_data_out,    // memory_data_bus driven
  output logic [7:0] mem_par_out,      // memory parity driven
  output logic mem_data_oe,            // memory_data_bus enable
  input wire logic [31:0] pci_ad_in,   // AD bus sampled
  output logic [31:0] pci_ad_out,      // AD bus driven
  output logic pci_ad_oe               // AD bus enable
);

  // ----------------------------------------------------------------------
  // Posted write queues
  // ----------------------------------------------------------------------
  logic cp_in_ready;
  logic cp_out_valid;
  logic [31:0] cp_out_data;
  logic cp_full;
  logic cp_empty;
  logic cm_in_ready;
  logic cm_out_valid;
  logic [63:0] cm_out_data;
  logic cm_full;
  logic cm_empty;

  // Four entries of four dwords each, flattened into one FIFO
  dbuf_fifo #(
    .WIDTH(32),
    .DEPTH(CP_DEPTH)
  ) u_cp_queue (
    .clk(clk),
    .rst(rst),
    .in_valid(ctrl.cp_push),
    .in_data(host_data_in[31:0]),
    .in_ready(cp_in_ready),
    .out_valid(cp_out_valid),
    .out_data(cp_out_data),
    .out_ready(ctrl.cp_pop),
    .full(cp_full),
    .empty(cp_empty)
  );

  // One burst line of four quadwords
  dbuf_fifo #(
    .WIDTH(64),
    .DEPTH(CM_DEPTH)
  ) u_cm_queue (
    .clk(clk),
    .rst(rst),
    .in_valid(ctrl.cm_push),
    .in_data(host_data_in),
    .in_ready(cm_in_ready),
    .out_valid(cm_out_valid),
    .out_data(cm_out_data),
    .out_ready(ctrl.cm_pop),
    .full(cm_full),
    .empty(cm_empty)
  );

  // ----------------------------------------------------------------------
  // Parity
  // ----------------------------------------------------------------------
  logic [63:0] wr_qw;
  logic [7:0] wr_par;
  logic [7:0] rd_par;
  logic [7:0] out_par_chk;

  dbuf_par #(.ODD(`DBUF_PAR_ODD)) u_wr_par (
    .data(wr_qw),
    .par(wr_par)
  );

  dbuf_par #(.ODD(`DBUF_PAR_ODD)) u_rd_par (
    .data(mem_data_in),
    .par(rd_par)
  );

  // Only the assertions read this one
  dbuf_par #(.ODD(`DBUF_PAR_ODD)) u_chk_par (
    .data(mem_data_out),
    .par(out_par_chk)
  );

  // ----------------------------------------------------------------------
  // Datapath state
  // ----------------------------------------------------------------------
  dbuf_state_s st_r;
  dbuf_state_s st_nxt;

  always_comb begin
    logic cp_push_ok;
    cp_push_ok = ctrl.cp_push && cp_in_ready;
    st_nxt = st_r;

    // Buses are driven only in the cycle after the commanding strobe
    st_nxt.host_oe = 1'b0;
    st_nxt.mem_oe = 1'b0;
    st_nxt.ad_oe = 1'b0;

    // Memory side: queued host words or the posted PCI quadword
    wr_qw = cm_out_data;
    if (ctrl.cm_pop && cm_out_valid) begin
      wr_qw = cm_out_data;
      st_nxt.mem_oe = 1'b1;
    end else if (ctrl.ptm_mem_oe) begin
      wr_qw = st_r.ptm;
      st_nxt.mem_oe = 1'b1;
    end
    if (st_nxt.mem_oe) begin
      st_nxt.mem_out = wr_qw;
      st_nxt.mem_par = wr_par;
    end

    // Memory to CPU: latch plus parity result
    if (ctrl.crm_le) begin
      st_nxt.crm = mem_data_in;
      st_nxt.par_err = (rd_par != mem_par_in);
    end

    // Memory or modified host line to PCI; no parity look here
    if (ctrl.prm_le_mem) begin
      st_nxt.prm = mem_data_in;
    end else if (ctrl.prm_le_host) begin
      st_nxt.prm = host_data_in;
    end

    // AD dwords assembled into the PCI-side latch
    if (ctrl.ptm_le) begin
      if (ctrl.ptm_sel) begin
        st_nxt.ptm[63:32] = pci_ad_in;
      end else begin
        st_nxt.ptm[31:0] = pci_ad_in;
      end
    end

    // AD bus: queue drain has priority over the read latch
    if (ctrl.cp_pop && cp_out_valid) begin
      st_nxt.ad_out = cp_out_data;
      st_nxt.ad_oe = 1'b1;
    end else if (ctrl.prm_oe) begin
      // Second dword only follows the controller's wait state
      st_nxt.ad_out = ctrl.prm_sel ? st_r.prm[63:32]
                                   : st_r.prm[31:0];
      st_nxt.ad_oe = 1'b1;
    end

    // Host bus: abort fill, PCI latch, then memory read latch
    if (ctrl.abort_oe) begin
      st_nxt.host_out = `DBUF_ABORT_QW;
      st_nxt.host_oe = 1'b1;
    end else if (ctrl.ptm_host_oe) begin
      st_nxt.host_out = st_r.ptm;
      st_nxt.host_oe = 1'b1;
    end else if (ctrl.crm_oe) begin
      st_nxt.host_out = st_r.crm;
      st_nxt.host_oe = 1'b1;
    end

    // I/O write is held until its data has left; set beats clear
    if (cp_push_ok && ctrl.cp_io) begin
      st_nxt.io_wait = 1'b1;
    end else if (cp_empty) begin
      st_nxt.io_wait = 1'b0;
    end
  end

  // Reset leaves every latch clear and every bus released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign host_data_out = st_r.host_out;
  assign host_data_oe = st_r.host_oe;
  assign mem_data_out = st_r.mem_out;
  assign mem_par_out = st_r.mem_par;
  assign mem_data_oe = st_r.mem_oe;
  assign pci_ad_out = st_r.ad_out;
  assign pci_ad_oe = st_r.ad_oe;

  // Full holds the CPU off; empty lets a CPU read of PCI go ahead
  assign stat.cp_full = cp_full;
  assign stat.cp_empty = cp_empty;
  assign stat.cm_full = cm_full;
  assign stat.cm_empty = cm_empty;
  assign stat.io_wait = st_r.io_wait;
  assign stat.par_err = st_r.par_err;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence cm_pop_s;
    ctrl.cm_pop && cm_out_valid;
  endsequence

  sequence cm_drive_s;
    mem_data_oe && mem_data_out == $past(cm_out_data);
  endsequence

  mem_write_path_a: assert property (
    cm_pop_s |=> cm_drive_s) else $error("queued word not on memory");

  mem_parity_gen_a: assert property (
    mem_data_oe |-> mem_par_out == out_par_chk)
    else $error("memory write parity wrong");

  crm_capture_a: assert property (
    ctrl.crm_le ##1 (ctrl.crm_oe && !ctrl.abort_oe && !ctrl.ptm_host_oe)
    |=> host_data_oe && host_data_out == $past(mem_data_in, 2))
    else $error("read latch lost memory data");

  parity_check_a: assert property (
    ctrl.crm_le |=> stat.par_err == ($past(rd_par) != $past(mem_par_in)))
    else $error("parity result wrong");

  no_pci_check_a: assert property (
    (ctrl.prm_le_mem && !ctrl.crm_le) |=> $stable(stat.par_err))
    else $error("parity flagged on PCI read");

  pci_drain_a: assert property (
    (ctrl.cp_pop && cp_out_valid)
    |=> pci_ad_oe && pci_ad_out == $past(cp_out_data))
    else $error("queue drain missing on AD");

  push_refused_a: assert property (
    (cp_full && !ctrl.cp_pop) |=> cp_full)
    else $error("push accepted while full");

  // Up from the cycle after the accepted push until one cycle after the queue shows empty
  io_hold_a: assert property (
    ((ctrl.cp_push && ctrl.cp_io && cp_in_ready)
      || (stat.io_wait && !cp_empty)) |=> stat.io_wait)
    else $error("I/O write completed early");

  io_bound_a: assert property (
    (stat.io_wait && cp_empty && !ctrl.cp_push) |=> !stat.io_wait)
    else $error("I/O wait stuck after drain");

  prm_high_a: assert property (
    (ctrl.prm_oe && ctrl.prm_sel && !ctrl.cp_pop)
    |=> pci_ad_out == $past(st_r.prm[63:32]))
    else $error("wrong dword from read latch");

  ptm_assemble_a: assert property (
    (ctrl.ptm_le && !ctrl.ptm_sel) |=> st_r.ptm[31:0] == $past(pci_ad_in))
    else $error("AD dword not assembled");

  abort_ones_a: assert property (
    ctrl.abort_oe |=> host_data_oe && host_data_out == `DBUF_ABORT_QW)
    else $error("abort data not all ones");

  idle_quiet_a: assert property (
    !(ctrl.abort_oe || ctrl.ptm_host_oe || ctrl.crm_oe) |=> !host_data_oe)
    else $error("host bus driven unasked");

  sequence ptm_to_host_s;
    ctrl.ptm_host_oe && !ctrl.abort_oe;
  endsequence

  sequence ptm_to_mem_s;
    ctrl.ptm_mem_oe && !(ctrl.cm_pop && cm_out_valid);
  endsequence

  ptm_host_a: assert property (
    ptm_to_host_s |=> host_data_oe && host_data_out == $past(st_r.ptm))
    else $error("posted PCI data not on host");

  ptm_mem_a: assert property (
    ptm_to_mem_s |=> mem_data_oe && mem_data_out == $past(st_r.ptm))
    else $error("posted PCI data not on memory");

  crm_drive_a: assert property (
    (ctrl.crm_oe && !ctrl.abort_oe && !ctrl.ptm_host_oe)
    |=> host_data_oe && host_data_out == $past(st_r.crm))
    else $error("read latch not on host");

  prm_low_a: assert property (
    (ctrl.prm_oe && !ctrl.prm_sel && !ctrl.cp_pop)
    |=> pci_ad_oe && pci_ad_out == $past(st_r.prm[31:0]))
    else $error("wrong low dword from read latch");

  prm_host_a: assert property (
    (ctrl.prm_le_host && !ctrl.prm_le_mem)
    |=> st_r.prm == $past(host_data_in))
    else $error("modified line not captured");

  par_hold_a: assert property (
    !ctrl.crm_le |=> $stable(stat.par_err))
    else $error("parity result changed unasked");

  cm_refused_a: assert property (
    (cm_full && !ctrl.cm_pop) |=> cm_full)
    else $error("line queue push accepted while full");

  ad_quiet_a: assert property (
    !(ctrl.cp_pop || ctrl.prm_oe) |=> !pci_ad_oe)
    else $error("AD bus driven unasked");

  mem_quiet_a: assert property (
    !(ctrl.cm_pop || ctrl.ptm_mem_oe) |=> !mem_data_oe)
    else $error("memory bus driven unasked");

endmodule

/* File: dbuf_far_model.sv */
/*
  Far-side model of the data buffer: memory array data with byte parity
  and a PCI agent presenting AD dwords. Assumes the bench sets the word
  to present and the enables, on the same clock as the buffer.
*/
`timescale 1ns/1ns
module dbuf_far_model (
  input wire logic clk,             // clock
  input wire logic [63:0] mem_word, // word the memory presents
  input wire logic mem_en,          // memory drives its bus
  input wire logic bad_par,         // corrupt parity of byte 0
  input wire logic [31:0] ad_word,  // dword the PCI agent presents
  input wire logic ad_en,           // PCI agent drives AD
  output logic [63:0] mem_data,     // memory data bus
  output logic [7:0] mem_par,       // memory parity, bit i for byte i
  output logic [31:0] ad_data       // AD bus
);
  logic [63:0] mem_last = 64'h0;
  logic [7:0] par_last = 8'h00;
  logic [31:0] ad_last = 32'h0;
  logic [7:0] par;

  // Even parity per byte, as stored with the data
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      par[i] = ^mem_word[8*i +: 8];
    end
  end

  // Buses change on the rising edge only; a released bus toggles every
  // cycle so a stale value never looks valid
  always_ff @(posedge clk) begin
    mem_last <= mem_en ? mem_word : ~mem_last;
    par_last <= mem_en ? (par ^ {7'h00, bad_par}) : ~par_last;
    ad_last <= ad_en ? ad_word : ~ad_last;
  end

  assign mem_data = mem_last;
  assign mem_par = par_last;
  assign ad_data = ad_last;
endmodule

/* File: dbuf_top_tb.sv */
/*
  Self-checking bench for the data buffer top: both write queues, the
  three latches, parity and master abort. Assumes the design files and
  the far-side model are compiled first.
*/
`timescale 1ns/1ns
module dbuf_top_tb
  import dbuf_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  dbuf_ctrl_s ctrl = '0;
  dbuf_stat_s stat;
  logic [63:0] host_in = 64'h0, host_out, mem_in, mem_out;
  logic [63:0] mem_word = 64'h0;
  logic [7:0] par_in, par_out;
  logic [31:0] ad_in, ad_out, ad_word = 32'h0;
  logic host_oe, mem_oe, ad_oe;
  logic mem_en = 1'b0, bad_par = 1'b0, ad_en = 1'b0;
  int bad_count = 0, checks = 0;

  always #5 clk = ~clk;

  dbuf_top uut (.clk(clk), .rst(rst), .ctrl(ctrl), .stat(stat),
    .host_data_in(host_in), .host_data_out(host_out),
    .host_data_oe(host_oe), .mem_data_in(mem_in), .mem_par_in(par_in),
    .mem_data_out(mem_out), .mem_par_out(par_out),
    .mem_data_oe(mem_oe), .pci_ad_in(ad_in), .pci_ad_out(ad_out),
    .pci_ad_oe(ad_oe));

  dbuf_far_model far (.clk(clk), .mem_word(mem_word), .mem_en(mem_en),
    .bad_par(bad_par), .ad_word(ad_word), .ad_en(ad_en),
    .mem_data(mem_in), .mem_par(par_in), .ad_data(ad_in));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [7:0] par8(input logic [63:0] q);
    for (int i = 0; i < 8; i++) begin
      par8[i] = ^q[8*i +: 8];
    end
  endfunction

  // One strobe for one cycle; returns where the registered answer settles
  task automatic fire(input dbuf_ctrl_s c, input logic [63:0] h);
    @(posedge clk);
    ctrl <= c;
    host_in <= h;
    @(posedge clk);
    ctrl <= '0;
    @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic sc_reset();
    chk("stat", 6'h14, stat);
    chk("oe", 3'h0, {host_oe, mem_oe, ad_oe});
  endtask

  // Fill the line queue, refuse a fifth word, drain in order
  task automatic sc_mem_queue();
    for (int i = 0; i < 4; i++) begin
      fire('{cm_push: 1'b1, default: 1'b0}, 64'h1111_0000_0000_0000 + i);
    end
    chk("cm_full", 1'b1, stat.cm_full);
    fire('{cm_push: 1'b1, default: 1'b0}, 64'hDEAD_0000_0000_0000);
    for (int i = 0; i < 4; i++) begin
      fire('{cm_pop: 1'b1, default: 1'b0}, 64'h0);
      chk("mem_oe", 1'b1, mem_oe);
      chk("mem_out", 64'h1111_0000_0000_0000 + i, mem_out);
    end
    chk("cm_empty", 1'b1, stat.cm_empty);
  endtask

  // Sixteen dwords fill the PCI queue; the seventeenth is held off
  task automatic sc_pci_queue();
    for (int i = 0; i < 16; i++) begin
      fire('{cp_push: 1'b1, default: 1'b0}, 64'hBAD0_0000_A000_0000 + i);
    end
    chk("cp_full", 1'b1, stat.cp_full);
    fire('{cp_push: 1'b1, default: 1'b0}, 64'h0000_0000_DEAD_0000);
    chk("cp_full", 1'b1, stat.cp_full);
    for (int i = 0; i < 16; i++) begin
      fire('{cp_pop: 1'b1, default: 1'b0}, 64'h0);
      chk("ad_oe", 1'b1, ad_oe);
      chk("ad_out", 32'hA000_0000 + i, ad_out);
    end
    chk("cp_empty", 1'b1, stat.cp_empty);
  endtask

  task automatic sc_io_write();
    fire('{cp_push: 1'b1, cp_io: 1'b1, default: 1'b0}, 64'h0000_0000_5A5A_0001);
    chk("io_wait", 1'b1, stat.io_wait);
    chk("cp_empty", 1'b0, stat.cp_empty);
    fire('{cp_pop: 1'b1, default: 1'b0}, 64'h0);
    chk("ad_out", 32'h5A5A_0001, ad_out);
    chk("io_wait", 1'b1, stat.io_wait);
    @(posedge clk);
    @(negedge clk);
    chk("io_wait", 1'b0, stat.io_wait);
  endtask

  // Bad parity flagged on the CPU path, ignored on the PCI path
  task automatic sc_mem_read();
    mem_word <= 64'h0123_4567_89AB_CDEF;
    mem_en <= 1'b1;
    bad_par <= 1'b1;
    fire('{crm_le: 1'b1, default: 1'b0}, 64'h0);
    chk("par_err", 1'b1, stat.par_err);
    bad_par <= 1'b0;
    fire('{crm_le: 1'b1, default: 1'b0}, 64'h0);
    chk("par_err", 1'b0, stat.par_err);
    mem_en <= 1'b0;
    fire('{crm_oe: 1'b1, default: 1'b0}, 64'h0);
    chk("host_oe", 1'b1, host_oe);
    chk("host_out", 64'h0123_4567_89AB_CDEF, host_out);
    mem_word <= 64'hFEDC_BA98_7654_3210;
    mem_en <= 1'b1;
    bad_par <= 1'b1;
    fire('{prm_le_mem: 1'b1, default: 1'b0}, 64'h0);
    chk("par_err", 1'b0, stat.par_err);
    mem_en <= 1'b0;
    bad_par <= 1'b0;
    fire('{prm_oe: 1'b1, default: 1'b0}, 64'h0);
    chk("ad_lo", 32'h7654_3210, ad_out);
    @(posedge clk);
    fire('{prm_oe: 1'b1, prm_sel: 1'b1, default: 1'b0}, 64'h0);
    chk("ad_hi", 32'hFEDC_BA98, ad_out);
    fire('{prm_le_host: 1'b1, default: 1'b0}, 64'hC0DE_0042_0000_0007);
    fire('{prm_oe: 1'b1, prm_sel: 1'b1, default: 1'b0}, 64'h0);
    chk("ad_hi", 32'hC0DE_0042, ad_out);
  endtask

  // Two AD dwords assembled, then sent to memory and to the host
  task automatic sc_pci_write();
    ad_word <= 32'h1357_9BDF;
    ad_en <= 1'b1;
    fire('{ptm_le: 1'b1, default: 1'b0}, 64'h0);
    ad_word <= 32'h0246_8ACE;
    fire('{ptm_le: 1'b1, ptm_sel: 1'b1, default: 1'b0}, 64'h0);
    ad_en <= 1'b0;
    fire('{ptm_mem_oe: 1'b1, default: 1'b0}, 64'h0);
    chk("mem_out", 64'h0246_8ACE_1357_9BDF, mem_out);
    chk("mem_par", par8(64'h0246_8ACE_1357_9BDF), par_out);
    fire('{ptm_host_oe: 1'b1, default: 1'b0}, 64'h0);
    chk("host_out", 64'h0246_8ACE_1357_9BDF, host_out);
  endtask

  task automatic sc_abort();
    fire('{abort_oe: 1'b1, default: 1'b0}, 64'h0);
    chk("host_oe", 1'b1, host_oe);
    chk("host_out", 64'hFFFF_FFFF_FFFF_FFFF, host_out);
  endtask

  // Reset in mid-run drops whatever both queues still hold
  task automatic sc_mid_reset();
    fire('{cm_push: 1'b1, cp_push: 1'b1, default: 1'b0}, 64'h0000_0077);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("stat", 6'h14, stat);
    chk("oe", 3'h0, {host_oe, mem_oe, ad_oe});
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    sc_reset();
    sc_mem_queue();
    sc_pci_queue();
    sc_io_write();
    sc_mem_read();
    sc_pci_write();
    sc_abort();
    sc_mid_reset();
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule
